// *** core/mmb_pkg.sv ***
/*
  Package for the mode select, memory map and expansion bus block:
  mode and target encodings, state codes, request/response carriers,
  map constants and bus phase counts.
  Assumes a single 200 MHz clock domain; all users write mmb_pkg::name.
*/
package mmb_pkg;

  // Mode code is {mode_select_in_1, mode_select_in_0} as sampled on the first clock after reset
  typedef enum logic [1:0] {
    MODE_BOOT   = 2'b00,
    MODE_TEST   = 2'b01,
    MODE_SINGLE = 2'b10,
    MODE_EXPAND = 2'b11
  } mmb_mode_t;

  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_REG  = 3'b001,
    TGT_RAM  = 3'b010,
    TGT_BOOT = 3'b011,
    TGT_ROM  = 3'b100,
    TGT_EEP  = 3'b101,
    TGT_EXT  = 3'b110
  } mmb_tgt_t;

  typedef enum logic [2:0] {
    ST_CAPTURE = 3'b000,
    ST_IDLE    = 3'b001,
    ST_ADDR    = 3'b010,
    ST_LATCH   = 3'b011,
    ST_DATA    = 3'b100
  } mmb_state_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mmb_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    mmb_tgt_t tgt;
    logic [7:0] rdata;
  } mmb_rsp_t;

  // Map figures; sizes of the memory arrays are plain defaults
  localparam logic [15:0] RAM_SIZE = 16'h0200;
  localparam logic [15:0] RAM_TOP = 16'h01ff;
  localparam logic [15:0] REG_SIZE = 16'h0040;
  localparam logic [15:0] BOOT_BASE = 16'hbf00;
  localparam logic [15:0] BOOT_SIZE = 16'h0100;
  localparam logic [15:0] BOOT_VEC_BASE = 16'hbfc0;
  localparam logic [15:0] VEC_BASE = 16'hffc0;
  localparam logic [15:0] ROM_BASE = 16'hd000;
  localparam logic [15:0] ROM_SIZE = 16'h3000;
  localparam logic [15:0] EEP_BASE = 16'hb600;
  localparam logic [15:0] EEP_SIZE = 16'h0200;
  localparam logic [11:0] PAGE_OFFSET_ZERO = 12'h000;
  localparam logic [3:0] RAM_RESET_PAGE = 4'h0;
  localparam logic [3:0] REG_RESET_PAGE = 4'h1;

  // Bus phase and start-up counts
  localparam logic [1:0] E_HIGH_LAST = 2'h3;
  localparam logic [1:0] MODE_CAP_WAIT = 2'h2;
  localparam logic [2:0] LOADER_IDLE_CHARS = 3'h4;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;

endpackage

// *** core/mmb_decode.sv ***
/*
  Address decoder: maps one 16-bit address to the on-chip resource or the
  external bus for the current mode and map positions.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps

module mmb_decode (
  input wire logic [15:0] addr,
  input wire mmb_pkg::mmb_mode_t mode,
  input wire logic [3:0] ram_page,
  input wire logic [3:0] reg_page,
  input wire logic rom_on,
  input wire logic eep_on,
  output mmb_pkg::mmb_tgt_t tgt
);

  function automatic logic in_win(input logic [15:0] a, input logic [15:0] base,
                                  input logic [15:0] size);
    in_win = (a >= base) && ((a - base) < size);
  endfunction

  logic [15:0] reg_base;
  logic [15:0] ram_base;
  logic rom_live;
  logic ext_ok;

  assign reg_base = {reg_page, mmb_pkg::PAGE_OFFSET_ZERO};
  assign ram_base = {ram_page, mmb_pkg::PAGE_OFFSET_ZERO};
  // Single-chip code has nowhere else to fetch vectors, so ROM stays on there
  assign rom_live = rom_on || (mode == mmb_pkg::MODE_SINGLE);
  assign ext_ok = (mode == mmb_pkg::MODE_EXPAND) || (mode == mmb_pkg::MODE_TEST);

  // Same order in every mode, so on-chip resources never move with mode
  always_comb begin
    tgt = mmb_pkg::TGT_NONE;
    if (in_win(addr, reg_base, mmb_pkg::REG_SIZE)) begin
      tgt = mmb_pkg::TGT_REG;
    end else if (in_win(addr, ram_base, mmb_pkg::RAM_SIZE)) begin
      tgt = mmb_pkg::TGT_RAM;
    end else if (mode == mmb_pkg::MODE_BOOT &&
                 in_win(addr, mmb_pkg::BOOT_BASE, mmb_pkg::BOOT_SIZE)) begin
      tgt = mmb_pkg::TGT_BOOT;
    end else if (rom_live && in_win(addr, mmb_pkg::ROM_BASE, mmb_pkg::ROM_SIZE)) begin
      tgt = mmb_pkg::TGT_ROM;
    end else if (eep_on && in_win(addr, mmb_pkg::EEP_BASE, mmb_pkg::EEP_SIZE)) begin
      tgt = mmb_pkg::TGT_EEP;
    end else if (ext_ok) begin
      tgt = mmb_pkg::TGT_EXT;
    end
  end

endmodule // mmb_decode

// *** core/mmb_top.sv ***
/*
  Mode capture, memory map decode and multiplexed expansion bus engine.
  Assumes: one clock clk_sys at 200 MHz, synchronous active-high rst,
  mode pins and port C/strobe A pins asynchronous to clk_sys, CPU and
  port logic on clk_sys. Bidirectional pins are split into in/out/enable.
*/
`timescale 1ns/1ps

// Summary of operation
// - Mode comes from mode pins after reset release
// - Single-chip: on-chip only, no external cycles
// - Expanded: whole 64K space, external elsewhere
// - Single-chip: ports B, C, strobes are GPIO
// - Single-chip: ROM enabled, vectors at FFC0-FFFF
// - Low address then data share port C
// - Address strobe high passes, falling edge latches
// - Address, R/W, strobe valid every cycle
// - R/W low, held across back-to-back writes
// - Bootstrap enables boot ROM BF00-BFFF
// - Bootstrap vectors decode to BFC0-BFFF
// - Loader exits to 0000 on idle/last byte
// - Bootstrap port D open-drain, external pull-up
// - Bootstrap interrupt vectors redirect into RAM
// - On-chip addresses identical in both modes
// - Config bits remove EEPROM, and EPROM outside single-chip
// - RAM at 0000, relocatable per 4K
// - Registers at 1000, relocatable per 4K
// - Registers win over RAM on overlap
// - Test mode is expanded plus privilege
// - Port B carries address 15-8
// - Port C carries address 7-0 first
module mmb_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic mode_select_in_0,
  input wire logic mode_select_in_1,
  input wire mmb_pkg::mmb_req_t req,
  output logic req_ready,
  output mmb_pkg::mmb_rsp_t rsp,
  input wire logic [3:0] ram_page,
  input wire logic [3:0] reg_page,
  input wire logic cfg_rom_on,
  input wire logic cfg_eep_on,
  input wire logic [7:0] gpio_b_out,
  input wire logic [7:0] gpio_c_out,
  input wire logic [7:0] gpio_c_oe,
  input wire logic gpio_strobe_b,
  input wire logic sci_rx_byte,
  input wire logic [15:0] sci_rx_addr,
  input wire logic sci_char_tick,
  output logic [7:0] port_b_pin_o,
  input wire logic [7:0] port_c_pin_i,
  output logic [7:0] port_c_pin_o,
  output logic [7:0] port_c_pin_oe,
  input wire logic strobe_a_pin_i,
  output logic strobe_a_pin_o,
  output logic strobe_a_pin_oe,
  output logic strobe_b_pin_o,
  output logic e_clk,
  output logic [7:0] port_c_in_sync,
  output logic port_c_latch_strobe_in,
  output mmb_pkg::mmb_mode_t mode,
  output logic mode_valid,
  output logic privileged,
  output logic port_d_wired_or,
  output logic vectors_to_ram,
  output logic loader_jump_to_zero
);

  typedef struct packed {
    logic [1:0] md_s1;
    logic [1:0] md_s2;
    logic [7:0] pc_s1;
    logic [7:0] pc_s2;
    logic sa_s1;
    logic sa_s2;
    logic [1:0] cap_wait;
    logic mode_ok;
    mmb_pkg::mmb_mode_t mode;
    mmb_pkg::mmb_state_t state;
    logic [1:0] e_cnt;
    logic wr;
    logic [7:0] wdata;
    mmb_pkg::mmb_tgt_t tgt;
    logic req_ready;
    mmb_pkg::mmb_rsp_t rsp;
    logic [7:0] pb_o;
    logic [7:0] pc_o;
    logic [7:0] pc_oe;
    logic sa_o;
    logic sa_oe;
    logic sb_o;
    logic e_o;
    logic [2:0] idle_cnt;
    logic boot_done;
    logic jump_zero;
    logic priv;
    logic d_wor;
    logic vram;
  } mmb_st_t;

  // Reset leaves port C and strobe A undriven and R/W at read, so no stray write
  localparam mmb_st_t ST_RESET = '{
    md_s1: 2'h0,
    md_s2: 2'h0,
    pc_s1: 8'h00,
    pc_s2: 8'h00,
    sa_s1: 1'b0,
    sa_s2: 1'b0,
    cap_wait: mmb_pkg::MODE_CAP_WAIT,
    mode_ok: 1'b0,
    mode: mmb_pkg::MODE_SINGLE,
    state: mmb_pkg::ST_CAPTURE,
    e_cnt: 2'h0,
    wr: 1'b0,
    wdata: 8'h00,
    tgt: mmb_pkg::TGT_NONE,
    req_ready: 1'b0,
    rsp: '{valid: 1'b0, err: 1'b0, tgt: mmb_pkg::TGT_NONE, rdata: 8'h00},
    pb_o: 8'h00,
    pc_o: 8'h00,
    pc_oe: 8'h00,
    sa_o: 1'b0,
    sa_oe: 1'b0,
    sb_o: 1'b1,
    e_o: 1'b0,
    idle_cnt: 3'h0,
    boot_done: 1'b0,
    jump_zero: 1'b0,
    priv: 1'b0,
    d_wor: 1'b0,
    vram: 1'b0
  };

  mmb_st_t s_q;
  mmb_st_t s_d;
  mmb_pkg::mmb_tgt_t dec_tgt;
  logic bus_mode;

  mmb_decode u_decode (
    .addr(req.addr),
    .mode(s_q.mode),
    .ram_page(ram_page),
    .reg_page(reg_page),
    .rom_on(cfg_rom_on),
    .eep_on(cfg_eep_on),
    .tgt(dec_tgt)
  );

  // Test mode runs the same bus as expanded mode
  assign bus_mode = (s_q.mode == mmb_pkg::MODE_EXPAND) ||
                    (s_q.mode == mmb_pkg::MODE_TEST);

  always_comb begin
    s_d = s_q;
    s_d.rsp.valid = 1'b0;
    s_d.jump_zero = 1'b0;

    // Two-stage synchronisers for every asynchronous pin
    s_d.md_s1 = {mode_select_in_1, mode_select_in_0};
    s_d.md_s2 = s_q.md_s1;
    s_d.pc_s1 = port_c_pin_i;
    s_d.pc_s2 = s_q.pc_s1;
    s_d.sa_s1 = strobe_a_pin_i;
    s_d.sa_s2 = s_q.sa_s1;

    case (s_q.state)
      mmb_pkg::ST_CAPTURE: begin
        // Synchronisers are cleared by reset, so wait until they carry the pins
        if (s_q.cap_wait != 2'h0) begin
          s_d.cap_wait = s_q.cap_wait - 2'h1;
        end else begin
          s_d.mode = mmb_pkg::mmb_mode_t'(s_q.md_s2);
          s_d.mode_ok = 1'b1;
          s_d.state = mmb_pkg::ST_IDLE;
          s_d.req_ready = 1'b1;
          // Flags follow the captured code and stay fixed until the next reset
          s_d.priv = (s_q.md_s2 == mmb_pkg::MODE_TEST);
          s_d.d_wor = (s_q.md_s2 == mmb_pkg::MODE_BOOT);
          s_d.vram = (s_q.md_s2 == mmb_pkg::MODE_BOOT);
        end
      end
      mmb_pkg::ST_IDLE: begin
        if (req.valid) begin
          s_d.wr = req.wr;
          s_d.wdata = req.wdata;
          s_d.tgt = dec_tgt;
          if (bus_mode) begin
            // Every access, internal or not, runs a visible bus cycle
            s_d.state = mmb_pkg::ST_ADDR;
            s_d.req_ready = 1'b0;
            s_d.pb_o = req.addr[15:8];
            s_d.pc_o = req.addr[7:0];
            s_d.pc_oe = mmb_pkg::BYTE_ONES;
            s_d.sa_o = 1'b1;
            s_d.sb_o = !req.wr;
          end else begin
            // On-chip only: unmapped addresses answer with an error, no bus cycle
            s_d.rsp.valid = 1'b1;
            s_d.rsp.err = (dec_tgt == mmb_pkg::TGT_NONE);
            s_d.rsp.tgt = dec_tgt;
            s_d.rsp.rdata = mmb_pkg::BYTE_ZERO;
          end
        end else if (bus_mode) begin
          s_d.sb_o = 1'b1;
        end
      end
      mmb_pkg::ST_ADDR: begin
        s_d.sa_o = 1'b0;
        s_d.state = mmb_pkg::ST_LATCH;
      end
      mmb_pkg::ST_LATCH: begin
        // Data half: device drives only for writes, pins float for reads
        s_d.e_o = 1'b1;
        s_d.e_cnt = 2'h0;
        s_d.pc_o = s_q.wdata;
        s_d.pc_oe = s_q.wr ? mmb_pkg::BYTE_ONES : mmb_pkg::BYTE_ZERO;
        s_d.state = mmb_pkg::ST_DATA;
      end
      mmb_pkg::ST_DATA: begin
        if (s_q.e_cnt != mmb_pkg::E_HIGH_LAST) begin
          s_d.e_cnt = s_q.e_cnt + 2'h1;
        end else begin
          // Sample late in E high so synchroniser delay still lands inside it
          s_d.e_o = 1'b0;
          s_d.pc_oe = mmb_pkg::BYTE_ZERO;
          s_d.rsp.valid = 1'b1;
          s_d.rsp.err = 1'b0;
          s_d.rsp.tgt = s_q.tgt;
          s_d.rsp.rdata = (!s_q.wr && s_q.tgt == mmb_pkg::TGT_EXT) ?
                          s_q.pc_s2 : mmb_pkg::BYTE_ZERO;
          s_d.req_ready = 1'b1;
          s_d.state = mmb_pkg::ST_IDLE;
        end
      end
      default: begin
        s_d.state = mmb_pkg::ST_CAPTURE;
      end
    endcase

    // Pins revert to parallel I/O once single-chip or bootstrap mode is captured
    if (s_q.mode_ok && !bus_mode) begin
      s_d.pb_o = gpio_b_out;
      s_d.pc_o = gpio_c_out;
      s_d.pc_oe = gpio_c_oe;
      s_d.sa_o = 1'b0;
      s_d.sa_oe = 1'b0;
      s_d.sb_o = gpio_strobe_b;
      s_d.e_o = 1'b0;
    end else if (s_q.mode_ok) begin
      s_d.sa_oe = 1'b1;
    end

    // Loader exit: idle character count, or last RAM byte received
    if (s_q.mode_ok && s_q.mode == mmb_pkg::MODE_BOOT && !s_q.boot_done) begin
      if (sci_rx_byte) begin
        s_d.idle_cnt = 3'h0;
        if (sci_rx_addr == mmb_pkg::RAM_TOP) begin
          s_d.boot_done = 1'b1;
          s_d.jump_zero = 1'b1;
        end
      end else if (sci_char_tick) begin
        s_d.idle_cnt = s_q.idle_cnt + 3'h1;
        if (s_q.idle_cnt + 3'h1 == mmb_pkg::LOADER_IDLE_CHARS) begin
          s_d.boot_done = 1'b1;
          s_d.jump_zero = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= ST_RESET;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign req_ready = s_q.req_ready;
  assign rsp = s_q.rsp;
  assign port_b_pin_o = s_q.pb_o;
  assign port_c_pin_o = s_q.pc_o;
  assign port_c_pin_oe = s_q.pc_oe;
  assign strobe_a_pin_o = s_q.sa_o;
  assign strobe_a_pin_oe = s_q.sa_oe;
  assign strobe_b_pin_o = s_q.sb_o;
  assign e_clk = s_q.e_o;
  assign port_c_in_sync = s_q.pc_s2;
  assign port_c_latch_strobe_in = s_q.sa_s2;
  assign mode = s_q.mode;
  assign mode_valid = s_q.mode_ok;
  assign privileged = s_q.priv;
  // Bootstrap mode capture sets port D open-drain; SCI transmit needs a pull-up
  assign port_d_wired_or = s_q.d_wor;
  assign vectors_to_ram = s_q.vram;
  assign loader_jump_to_zero = s_q.jump_zero;

endmodule // mmb_top

// *** verification/mmb_monitor.sv ***
/* Checker for the mmb_top pins and request handshake.
   Assumes clk_en stays high through bus cycles; bound to mmb_top from the bench. */
`timescale 1ns/1ps
module mmb_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire mmb_pkg::mmb_req_t req,
  input wire logic req_ready,
  input wire mmb_pkg::mmb_rsp_t rsp,
  input wire logic [7:0] port_b_pin_o,
  input wire logic [7:0] port_c_pin_o,
  input wire logic [7:0] port_c_pin_oe,
  input wire logic strobe_a_pin_o,
  input wire logic strobe_a_pin_oe,
  input wire logic strobe_b_pin_o,
  input wire logic e_clk,
  input wire mmb_pkg::mmb_mode_t mode,
  input wire logic mode_valid,
  input wire logic privileged,
  input wire logic vectors_to_ram,
  input wire logic loader_jump_to_zero
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic take;
  logic bus;
  mmb_pkg::mmb_req_t last_q;
  assign take = clk_en && req.valid && req_ready;
  assign bus = mode_valid && mode[0];
  always_ff @(posedge clk_sys) begin
    if (take) begin
      last_q <= req;
    end
  end
  addr_phase_a: assert property ($rose(strobe_a_pin_o) |-> bus
    && port_b_pin_o == last_q.addr[15:8] && port_c_pin_o == last_q.addr[7:0]
    && port_c_pin_oe == 8'hff && strobe_b_pin_o == !last_q.wr)
    else $error("address phase wrong");
  latch_data_a: assert property ($rose(strobe_a_pin_o) |=>
    !strobe_a_pin_o && !e_clk ##1 e_clk && port_c_pin_oe == {8{last_q.wr}}
    && (!last_q.wr || port_c_pin_o == last_q.wdata))
    else $error("latch or data phase wrong");
  e_high_a: assert property ($rose(e_clk) |-> e_clk[*4] ##1
    (!e_clk && port_c_pin_oe == 8'h00 && rsp.valid && req_ready))
    else $error("data half length wrong");
  onchip_only_a: assert property (mode_valid && !mode[0] |->
    !strobe_a_pin_oe && !(rsp.valid && rsp.tgt == mmb_pkg::TGT_EXT))
    else $error("bus activity in on-chip mode");
  onchip_rsp_a: assert property (mode_valid && !mode[0] && take |=> rsp.valid)
    else $error("on-chip answer late");
  rw_held_a: assert property (bus && take && req.wr && !strobe_b_pin_o |=>
    !strobe_b_pin_o)
    else $error("write line released between writes");
  mode_hold_a: assert property (mode_valid && $past(mode_valid) |-> $stable(mode))
    else $error("mode changed after capture");
  mode_flags_a: assert property (mode_valid && $past(mode_valid) |->
    vectors_to_ram == (mode == mmb_pkg::MODE_BOOT)
    && privileged == (mode == mmb_pkg::MODE_TEST))
    else $error("mode flags wrong");
  loader_a: assert property (loader_jump_to_zero |->
    mode == mmb_pkg::MODE_BOOT ##1 !loader_jump_to_zero)
    else $error("loader pulse wrong");
endmodule // mmb_monitor

// *** verification/mmb_ext_mem.sv ***
/* External address latch and byte memory on the expansion pins.
   Assumes the bench resolves port C from both drivers. */
`timescale 1ns/1ps
module mmb_ext_mem (
  input wire logic clk_sys,
  input wire logic [7:0] addr_hi,
  input wire logic [7:0] pins_o,
  input wire logic strobe,
  input wire logic rw,
  input wire logic e_clk,
  output logic [7:0] drv,
  output logic drv_en
);
  logic [7:0] lo_q;
  logic [7:0] last_q = 8'h00;
  logic [7:0] mem [0:65535];
  logic we_n;
  always_latch if (strobe) lo_q <= pins_o;
  assign we_n = !(e_clk && !rw);
  assign drv_en = e_clk && rw;
  // Released lines show the inverse so a stale byte cannot pass
  assign drv = drv_en ? mem[{addr_hi, lo_q}] : ~last_q;
  always @(posedge clk_sys) begin
    if (!we_n) mem[{addr_hi, lo_q}] <= pins_o;
    if (drv_en) last_q <= drv;
  end
endmodule // mmb_ext_mem

// *** verification/testbench.sv ***
/* Bench for mmb_top: resets into each mode, checks decode, pins,
   bus transfers and loader exit. Assumes mmb_ext_mem on the bus. */
`timescale 1ns/1ps
module testbench;
  logic clk_sys, rst, clk_en, mode_select_in_0, mode_select_in_1, req_ready;
  logic cfg_rom_on, cfg_eep_on, gpio_strobe_b, sci_rx_byte, sci_char_tick;
  logic strobe_a_pin_i, strobe_a_pin_o, strobe_a_pin_oe, strobe_b_pin_o, e_clk;
  logic port_c_latch_strobe_in, mode_valid, privileged, port_d_wired_or;
  logic vectors_to_ram, loader_jump_to_zero, ext_en;
  logic [3:0] ram_page, reg_page;
  logic [7:0] gpio_b_out, gpio_c_out, gpio_c_oe, port_b_pin_o, port_c_pin_i;
  logic [7:0] port_c_pin_o, port_c_pin_oe, port_c_in_sync, ext_d;
  logic [15:0] sci_rx_addr;
  mmb_pkg::mmb_req_t req;
  mmb_pkg::mmb_rsp_t rsp;
  mmb_pkg::mmb_mode_t mode;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  int jumps = 0;
  mmb_top dut_u (.*);
  mmb_ext_mem ext_u (.clk_sys(clk_sys), .addr_hi(port_b_pin_o), .pins_o(port_c_pin_o),
    .strobe(strobe_a_pin_o), .rw(strobe_b_pin_o), .e_clk(e_clk), .drv(ext_d), .drv_en(ext_en));
  assign port_c_pin_i = (port_c_pin_o & port_c_pin_oe) | (ext_d & ~port_c_pin_oe);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (loader_jump_to_zero === 1'b1) jumps <= jumps + 1;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  function automatic logic [15:0] w(input logic e, input mmb_pkg::mmb_tgt_t t,
                                     input logic [7:0] d);
    return {4'h0, e, t, d};
  endfunction
  task automatic boot(input logic [1:0] m);
    mode_select_in_1 <= m[1];
    mode_select_in_0 <= m[0];
    rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    check({13'h0, mode_valid, mode}, {13'h1, m});
  endtask
  task automatic take(input logic keep);
    for (int n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (req_ready === 1'b1) break;
    end
    if (!keep) req.valid <= 1'b0;
  endtask
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     input logic [15:0] want);
    mmb_pkg::mmb_rsp_t got;
    got = '0;
    req <= '{1'b1, wr, a, d};
    take(1'b0);
    for (int n = 0; n < 12 && got.valid !== 1'b1; n++) begin
      @(posedge clk_sys);
      got = rsp;
    end
    check({4'h0, got.err, got.tgt, got.rdata}, want);
  endtask
  task automatic tick(input int k, input logic [15:0] a);
    repeat (k) begin
      sci_char_tick <= (a == 16'h0);
      sci_rx_byte <= (a != 16'h0);
      sci_rx_addr <= a;
      @(posedge clk_sys);
      sci_char_tick <= 1'b0;
      sci_rx_byte <= 1'b0;
      @(posedge clk_sys);
    end
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic t_single;
    boot(2'b10);
    acc(1'b0, 16'h0000, 8'h00, w(1'b0, mmb_pkg::TGT_RAM, 8'h00));
    acc(1'b0, 16'h1000, 8'h00, w(1'b0, mmb_pkg::TGT_REG, 8'h00));
    acc(1'b0, 16'hffc0, 8'h00, w(1'b0, mmb_pkg::TGT_ROM, 8'h00));
    acc(1'b0, 16'h8000, 8'h00, w(1'b1, mmb_pkg::TGT_NONE, 8'h00));
    acc(1'b0, 16'hb600, 8'h00, w(1'b1, mmb_pkg::TGT_NONE, 8'h00));
    cfg_eep_on <= 1'b1;
    ram_page <= 4'h2;
    reg_page <= 4'h2;
    acc(1'b0, 16'hb600, 8'h00, w(1'b0, mmb_pkg::TGT_EEP, 8'h00));
    acc(1'b0, 16'h2010, 8'h00, w(1'b0, mmb_pkg::TGT_REG, 8'h00));
    acc(1'b0, 16'h2040, 8'h00, w(1'b0, mmb_pkg::TGT_RAM, 8'h00));
    reg_page <= 4'h3;
    acc(1'b0, 16'h3010, 8'h00, w(1'b0, mmb_pkg::TGT_REG, 8'h00));
    ram_page <= 4'h0;
    reg_page <= 4'h1;
    cfg_eep_on <= 1'b0;
    check({port_b_pin_o, port_c_pin_o}, 16'hc35a);
    check({port_c_pin_oe, 7'h0, strobe_b_pin_o}, 16'h0f00);
    clk_en <= 1'b0;
    gpio_b_out <= 8'h3c;
    repeat (3) @(posedge clk_sys);
    check({8'h0, port_b_pin_o}, 16'h00c3);
    clk_en <= 1'b1;
    strobe_a_pin_i <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({port_b_pin_o, port_c_in_sync}, 16'h3cfa);
    check({15'h0, port_c_latch_strobe_in}, 16'h0001);
    strobe_a_pin_i <= 1'b0;
    $display("single-chip test done");
  endtask
  task automatic t_expand;
    boot(2'b11);
    mode_select_in_1 <= 1'b0;
    req <= '{1'b1, 1'b1, 16'h4000, 8'ha5};
    take(1'b1);
    req <= '{1'b1, 1'b1, 16'h4001, 8'h3c};
    take(1'b0);
    repeat (9) @(posedge clk_sys);
    acc(1'b0, 16'h4000, 8'h00, w(1'b0, mmb_pkg::TGT_EXT, 8'ha5));
    acc(1'b0, 16'h4001, 8'h00, w(1'b0, mmb_pkg::TGT_EXT, 8'h3c));
    acc(1'b0, 16'h0000, 8'h00, w(1'b0, mmb_pkg::TGT_RAM, 8'h00));
    cfg_rom_on <= 1'b1;
    acc(1'b0, 16'hffc0, 8'h00, w(1'b0, mmb_pkg::TGT_ROM, 8'h00));
    cfg_rom_on <= 1'b0;
    acc(1'b1, 16'hffc0, 8'h77, w(1'b0, mmb_pkg::TGT_EXT, 8'h00));
    acc(1'b0, 16'hffc0, 8'h00, w(1'b0, mmb_pkg::TGT_EXT, 8'h77));
    check({14'h0, mode}, 16'h0003);
    $display("expanded test done");
  endtask
  task automatic t_boot;
    boot(2'b00);
    acc(1'b0, 16'hbf00, 8'h00, w(1'b0, mmb_pkg::TGT_BOOT, 8'h00));
    acc(1'b0, 16'hbfc0, 8'h00, w(1'b0, mmb_pkg::TGT_BOOT, 8'h00));
    check({14'h0, vectors_to_ram, port_d_wired_or}, 16'h0003);
    tick(3, 16'h0000);
    tick(1, 16'h0100);
    tick(3, 16'h0000);
    check(16'(jumps), 16'h0000);
    tick(1, 16'h0000);
    check(16'(jumps), 16'h0001);
    boot(2'b00);
    tick(1, 16'h01ff);
    check(16'(jumps), 16'h0002);
    $display("bootstrap test done");
  endtask
  task automatic t_test;
    boot(2'b01);
    check({15'h0, privileged}, 16'h0001);
    acc(1'b1, 16'h5000, 8'h96, w(1'b0, mmb_pkg::TGT_EXT, 8'h00));
    acc(1'b0, 16'h5000, 8'h00, w(1'b0, mmb_pkg::TGT_EXT, 8'h96));
    $display("test mode test done");
  endtask
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    mode_select_in_0 = 1'b0;
    mode_select_in_1 = 1'b1;
    req = '0;
    cfg_rom_on = 1'b0;
    cfg_eep_on = 1'b0;
    ram_page = 4'h0;
    reg_page = 4'h1;
    gpio_b_out = 8'hc3;
    gpio_c_out = 8'h5a;
    gpio_c_oe = 8'h0f;
    gpio_strobe_b = 1'b0;
    strobe_a_pin_i = 1'b0;
    sci_rx_byte = 1'b0;
    sci_rx_addr = 16'h0000;
    sci_char_tick = 1'b0;
    @(posedge clk_sys);
    t_single();
    t_expand();
    t_boot();
    t_test();
    stop_test();
  end
endmodule // testbench
bind mmb_top mmb_monitor mon_u (.*);
